/* src/cotr_defines.svh */
// Address map, field positions and reset values of the offset trim bank
`ifndef COTR_DEFINES_SVH
`define COTR_DEFINES_SVH
`define COTR_ADDR_W 12
`define COTR_IDX_W 10
`define COTR_IDX_FIRST_B 10'h08c
`define COTR_IDX_SECOND_A 10'h08e
`define COTR_IDX_SECOND_B 10'h090
`define COTR_IDX_CTRL 10'h0a0
`define COTR_IDX_STATUS 10'h0a1
`define COTR_TRIM_W 16
`define COTR_CORR_W 12
`define COTR_CORR_MSB 11
`define COTR_RSV_RESET 4'h0
`define COTR_NUM_TRIM 3
`define COTR_CTRL_W 3
`define COTR_CTRL_RESET 3'h0
`define COTR_CTRL_OS_BIT 0
`define COTR_CTRL_BG_BIT 1
`define COTR_CTRL_BGOS_BIT 2
`define COTR_STAT_BUSY_BIT 0
`define COTR_STAT_DONE_BIT 1
`define COTR_STAT_STOP_BIT 2
`define COTR_STAT_WVIOL_BIT 3
`define COTR_STAT_RVIOL_BIT 4
`define COTR_RESP_OKAY 2'h0
`define COTR_RESP_SLVERR 2'h2
`endif

/* src/cotr_pkg.sv */
// Shared types of the offset trim bank
package cotr_pkg;
   typedef logic [15:0] cotr_trim_t;
   typedef logic [11:0] cotr_corr_t;
   typedef logic [9:0] cotr_idx_t;
endpackage : cotr_pkg

/* src/cotr_trim_reg.sv */
// One 16-bit offset trim register with factory load and byte writes
`include "cotr_defines.svh"
module cotr_trim_reg (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Factory trim, sampled while reset is held
   input wire cotr_pkg::cotr_corr_t factory_value,
   // Software write
   input wire logic wr_en,
   input wire logic [1:0] wr_strb,
   input wire cotr_pkg::cotr_trim_t wr_data,
   // Stored word
   output cotr_pkg::cotr_trim_t value
);
   cotr_pkg::cotr_trim_t value_reg;
   cotr_pkg::cotr_trim_t value_next;

   always_comb begin
      value_next = value_reg;
      if (wr_en && wr_strb[0]) begin
         value_next[7:0] = wr_data[7:0];
      end
      if (wr_en && wr_strb[1]) begin
         value_next[15:8] = wr_data[15:8];
      end
   end

   // Reset is synchronous, so loading the trim port here is safe
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         value_reg <= {`COTR_RSV_RESET, factory_value};
      end else begin
         value_reg <= value_next;
      end
   end

   assign value = value_reg;
endmodule : cotr_trim_reg

/* src/cotr_offset_trim.sv */
// AXI4-Lite offset trim bank for the interleaved converter cores
// What this block does
// - First core, input B uses its 12-bit trim
// - Second core, input A uses trim at 0x08E
// - Second core, input B uses trim at 0x090
// - Trims load factory value; software reads, overwrites
//
// Chosen here: the AXI4-Lite register port.
`include "cotr_defines.svh"
module cotr_offset_trim (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [`COTR_ADDR_W-1:0] s_awaddr,
   input wire logic [2:0] s_awprot,
   input wire logic s_awvalid,
   output logic s_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   // AXI4-Lite write response
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   // AXI4-Lite read address
   input wire logic [`COTR_ADDR_W-1:0] s_araddr,
   input wire logic [2:0] s_arprot,
   input wire logic s_arvalid,
   output logic s_arready,
   // AXI4-Lite read data
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // Factory trim values, taken while reset is held
   input wire cotr_pkg::cotr_corr_t factory_first_core_input_b,
   input wire cotr_pkg::cotr_corr_t factory_second_core_input_a,
   input wire cotr_pkg::cotr_corr_t factory_second_core_input_b,
   // Calibration engine status
   input wire logic foreground_calibration_busy,
   input wire logic foreground_calibration_done_flag,
   input wire logic calibration_stopped_flag,
   // Calibration enables towards the engine
   output logic foreground_offset_calibration_enable,
   output logic background_calibration_enable,
   output logic background_offset_calibration_enable,
   // Sampling path
   input wire logic second_core_samples_b,
   output cotr_pkg::cotr_corr_t first_core_input_b_offset,
   output cotr_pkg::cotr_corr_t second_core_offset
);
   localparam cotr_pkg::cotr_idx_t TRIM_IDX [0:`COTR_NUM_TRIM-1] = '{
      `COTR_IDX_FIRST_B,
      `COTR_IDX_SECOND_A,
      `COTR_IDX_SECOND_B
   };

   // Write channel state
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic aw_got_reg;
   logic w_got_reg;
   cotr_pkg::cotr_idx_t aw_idx_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;

   // Read channel state
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;

   // Control and status
   logic [`COTR_CTRL_W-1:0] ctrl_reg;
   logic [`COTR_CTRL_W-1:0] ctrl_next;
   logic wviol_reg;
   logic wviol_next;
   logic rviol_reg;
   logic rviol_next;

   // Applied corrections
   cotr_pkg::cotr_corr_t first_b_corr_reg;
   cotr_pkg::cotr_corr_t second_corr_reg;

   // Decode
   // Register index is the word address; byte lanes 2 and 3 are unused
   wire aw_hs = s_awvalid && awready_reg;
   wire w_hs = s_wvalid && wready_reg;
   wire ar_hs = s_arvalid && arready_reg;
   wire do_write = aw_got_reg && w_got_reg && !bvalid_reg;
   wire cotr_pkg::cotr_idx_t rd_idx = s_araddr[`COTR_ADDR_W-1:2];
   wire hit_w_ctrl = aw_idx_reg == `COTR_IDX_CTRL;
   wire hit_w_stat = aw_idx_reg == `COTR_IDX_STATUS;
   wire hit_r_ctrl = rd_idx == `COTR_IDX_CTRL;
   wire hit_r_stat = rd_idx == `COTR_IDX_STATUS;
   wire wr_ctrl = do_write && hit_w_ctrl && wstrb_reg[0];
   wire wr_stat = do_write && hit_w_stat && wstrb_reg[0];

   wire os_en = ctrl_reg[`COTR_CTRL_OS_BIT];
   wire bg_en = ctrl_reg[`COTR_CTRL_BG_BIT];
   wire bgos_en = ctrl_reg[`COTR_CTRL_BGOS_BIT];

   // The engine owns the trims while either condition holds
   wire write_forbidden = foreground_calibration_busy
      || (bg_en && bgos_en);
   wire read_unsafe =
      (os_en && !bgos_en && !foreground_calibration_done_flag)
      || (bg_en && bgos_en && !calibration_stopped_flag);

   // Per-register hits and storage
   cotr_pkg::cotr_trim_t trim_val [0:`COTR_NUM_TRIM-1];
   cotr_pkg::cotr_corr_t factory [0:`COTR_NUM_TRIM-1];
   logic [`COTR_NUM_TRIM-1:0] hit_w_trim;
   logic [`COTR_NUM_TRIM-1:0] hit_r_trim;
   logic [`COTR_NUM_TRIM-1:0] trim_wr;

   assign factory[0] = factory_first_core_input_b;
   assign factory[1] = factory_second_core_input_a;
   assign factory[2] = factory_second_core_input_b;

   genvar gi;
   generate
      for (gi = 0; gi < `COTR_NUM_TRIM; gi++) begin : g_trim
         assign hit_w_trim[gi] = aw_idx_reg == TRIM_IDX[gi];
         assign hit_r_trim[gi] = rd_idx == TRIM_IDX[gi];
         assign trim_wr[gi] = do_write && hit_w_trim[gi];
         cotr_trim_reg u_trim (
            .aclk(aclk),
            .aresetn(aresetn),
            .factory_value(factory[gi]),
            .wr_en(trim_wr[gi]),
            .wr_strb(wstrb_reg[1:0]),
            .wr_data(wdata_reg[15:0]),
            .value(trim_val[gi])
         );
      end
   endgenerate

   wire any_w_trim = |hit_w_trim;
   wire any_r_trim = |hit_r_trim;
   wire w_mapped = any_w_trim || hit_w_ctrl || hit_w_stat;
   wire r_mapped = any_r_trim || hit_r_ctrl || hit_r_stat;

   // Read word selection; bits above each register read as zero
   wire [`COTR_STAT_RVIOL_BIT:0] stat_bits;
   assign stat_bits[`COTR_STAT_BUSY_BIT] = foreground_calibration_busy;
   assign stat_bits[`COTR_STAT_DONE_BIT] = foreground_calibration_done_flag;
   assign stat_bits[`COTR_STAT_STOP_BIT] = calibration_stopped_flag;
   assign stat_bits[`COTR_STAT_WVIOL_BIT] = wviol_reg;
   assign stat_bits[`COTR_STAT_RVIOL_BIT] = rviol_reg;
   // Widened on purpose: the flags sit in the low bits only
   wire [31:0] stat_word = 32'(stat_bits);
   wire [31:0] ctrl_word = {29'h00000000, ctrl_reg};
   wire [31:0] trim_word =
      hit_r_trim[0] ? {16'h0000, trim_val[0]} :
      hit_r_trim[1] ? {16'h0000, trim_val[1]} :
      hit_r_trim[2] ? {16'h0000, trim_val[2]} : 32'h00000000;
   wire [31:0] rd_word =
      hit_r_ctrl ? ctrl_word :
      hit_r_stat ? stat_word : trim_word;

   // Control register and sticky flags; a new event beats the clear
   always_comb begin
      ctrl_next = ctrl_reg;
      if (wr_ctrl) begin
         ctrl_next = wdata_reg[`COTR_CTRL_W-1:0];
      end
      wviol_next = wviol_reg;
      if (wr_stat && wdata_reg[`COTR_STAT_WVIOL_BIT]) begin
         wviol_next = 1'b0;
      end
      if (do_write && any_w_trim && write_forbidden) begin
         wviol_next = 1'b1;
      end
      rviol_next = rviol_reg;
      if (wr_stat && wdata_reg[`COTR_STAT_RVIOL_BIT]) begin
         rviol_next = 1'b0;
      end
      if (ar_hs && any_r_trim && read_unsafe) begin
         rviol_next = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= `COTR_CTRL_RESET;
         wviol_reg <= 1'b0;
         rviol_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         wviol_reg <= wviol_next;
         rviol_reg <= rviol_next;
      end
   end

   // Ready returns only when the response is taken: one write at a time
   // Write address and data are taken independently, in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b1;
         aw_got_reg <= 1'b0;
         aw_idx_reg <= 10'h000;
      end else if (aw_hs) begin
         awready_reg <= 1'b0;
         aw_got_reg <= 1'b1;
         aw_idx_reg <= s_awaddr[`COTR_ADDR_W-1:2];
      end else if (do_write) begin
         aw_got_reg <= 1'b0;
      end else if (s_bready && bvalid_reg) begin
         awready_reg <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wready_reg <= 1'b1;
         w_got_reg <= 1'b0;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
      end else if (w_hs) begin
         wready_reg <= 1'b0;
         w_got_reg <= 1'b1;
         wdata_reg <= s_wdata;
         wstrb_reg <= s_wstrb;
      end else if (do_write) begin
         w_got_reg <= 1'b0;
      end else if (s_bready && bvalid_reg) begin
         wready_reg <= 1'b1;
      end
   end

   // Response one cycle after both halves are held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= `COTR_RESP_OKAY;
      end else if (do_write) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= w_mapped ? `COTR_RESP_OKAY : `COTR_RESP_SLVERR;
      end else if (s_bready && bvalid_reg) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Unsafe trim reads still answer; the sticky flag records them
   // Reads answer on the same edge that takes the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rresp_reg <= `COTR_RESP_OKAY;
         rdata_reg <= 32'h00000000;
      end else if (ar_hs) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rresp_reg <= r_mapped ? `COTR_RESP_OKAY : `COTR_RESP_SLVERR;
         rdata_reg <= rd_word;
      end else if (s_rready && rvalid_reg) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
      end
   end

   // Registered so the sampling path never sees the bus decode
   // Only the low twelve bits reach the sampling path
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_b_corr_reg <= 12'h000;
         second_corr_reg <= 12'h000;
      end else begin
         first_b_corr_reg <= trim_val[0][`COTR_CORR_MSB:0];
         if (second_core_samples_b) begin
            second_corr_reg <= trim_val[2][`COTR_CORR_MSB:0];
         end else begin
            second_corr_reg <= trim_val[1][`COTR_CORR_MSB:0];
         end
      end
   end

   // Outputs
   assign s_awready = awready_reg;
   assign s_wready = wready_reg;
   assign s_bvalid = bvalid_reg;
   assign s_bresp = bresp_reg;
   assign s_arready = arready_reg;
   assign s_rvalid = rvalid_reg;
   assign s_rresp = rresp_reg;
   assign s_rdata = rdata_reg;
   assign foreground_offset_calibration_enable = os_en;
   assign background_calibration_enable = bg_en;
   assign background_offset_calibration_enable = bgos_en;
   assign first_core_input_b_offset = first_b_corr_reg;
   assign second_core_offset = second_corr_reg;
endmodule : cotr_offset_trim

/* verification/cotr_offset_trim_props.sv */
// Port-level checker of the offset trim bank
module cotr_offset_trim_props (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Register bus handshakes
   input wire logic s_awvalid,
   input wire logic s_awready,
   input wire logic s_wvalid,
   input wire logic s_wready,
   input wire logic [1:0] s_bresp,
   input wire logic s_bvalid,
   input wire logic s_bready,
   input wire logic s_arvalid,
   input wire logic s_arready,
   input wire logic [31:0] s_rdata,
   input wire logic s_rvalid,
   input wire logic s_rready,
   // Sampling path
   input wire logic second_core_samples_b,
   input wire cotr_pkg::cotr_corr_t first_core_input_b_offset,
   input wire cotr_pkg::cotr_corr_t second_core_offset
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence both_taken;
      s_awvalid && s_awready && s_wvalid && s_wready;
   endsequence
   // Halves are held one cycle, then the answer rises
   sequence write_answer;
      !s_awready && !s_wready ##1 s_bvalid;
   endsequence
   // A trim only moves the outputs one cycle after a write lands
   sequence no_update;
      $past(aresetn) && !$rose(s_bvalid);
   endsequence
   write_answer_a: assert property (both_taken |=> write_answer)
      else $error("write answer missing");
   write_hold_a: assert property (s_bvalid && !s_bready |=>
      s_bvalid && $stable(s_bresp)) else $error("write answer dropped");
   busy_refuse_a: assert property (s_bvalid |-> !s_awready && !s_wready)
      else $error("write taken while pending");
   read_answer_a: assert property (s_arvalid && s_arready |=>
      s_rvalid && !s_arready) else $error("read answer missing");
   read_hold_a: assert property (s_rvalid && !s_rready |=>
      s_rvalid && $stable(s_rdata)) else $error("read answer dropped");
   upper_zero_a: assert property (s_rvalid |-> s_rdata[31:16] == 16'h0)
      else $error("upper read bits set");
   first_hold_a: assert property (no_update |=>
      $stable(first_core_input_b_offset)) else $error("first offset moved");
   second_hold_a: assert property (no_update ##0
      $stable(second_core_samples_b) |=> $stable(second_core_offset))
      else $error("second offset moved");
endmodule : cotr_offset_trim_props

bind cotr_offset_trim cotr_offset_trim_props i_cotr_offset_trim_props (.*);

/* verification/testbench.sv */
// Self-checking bench of the offset trim bank
`include "cotr_defines.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [11:0] CTL = {`COTR_IDX_CTRL, 2'h0};
   localparam logic [11:0] STA = {`COTR_IDX_STATUS, 2'h0};
   localparam logic [11:0] TA [3] = '{{`COTR_IDX_FIRST_B, 2'h0},
      {`COTR_IDX_SECOND_A, 2'h0}, {`COTR_IDX_SECOND_B, 2'h0}};
   logic aclk = 1'h0, aresetn = 1'h0;
   logic [11:0] s_awaddr = 12'h0, s_araddr = 12'h0;
   logic [2:0] s_awprot = 3'h0, s_arprot = 3'h0;
   logic [31:0] s_wdata = 32'h0, s_rdata, d;
   logic [3:0] s_wstrb = 4'h0;
   logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0;
   logic s_arvalid = 1'h0, s_rready = 1'h0, second_core_samples_b = 1'h0;
   logic foreground_calibration_busy = 1'h0, calibration_stopped_flag = 1'h0;
   logic foreground_calibration_done_flag = 1'h0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp, resp;
   logic foreground_offset_calibration_enable, background_calibration_enable;
   logic background_offset_calibration_enable;
   cotr_pkg::cotr_corr_t factory_first_core_input_b = 12'h0;
   cotr_pkg::cotr_corr_t factory_second_core_input_a = 12'h0;
   cotr_pkg::cotr_corr_t factory_second_core_input_b = 12'h0;
   cotr_pkg::cotr_corr_t first_core_input_b_offset, second_core_offset;
   logic [15:0] m_trim [3];
   logic [2:0] m_ctrl;
   logic m_busy, m_done, m_stop, wvio, rvio;
   int errors = 0, total_checks = 0;

   cotr_offset_trim i_cotr_offset_trim (.*);

   always #50 aclk = ~aclk;

   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // Ready is raised late at random so the slave must hold its answer
   task automatic wr(logic [11:0] a, logic [31:0] v, logic [3:0] st);
      @(posedge aclk);
      s_awaddr <= a;
      s_wdata <= v;
      s_wstrb <= st;
      s_awvalid <= 1'h1;
      s_wvalid <= 1'h1;
      s_bready <= 1'($urandom);
      forever begin
         @(posedge aclk);
         if (s_awready) s_awvalid <= 1'h0;
         if (s_wready) s_wvalid <= 1'h0;
         if (s_bvalid && s_bready) break;
         if (!s_bready) s_bready <= 1'($urandom);
      end
      resp = s_bresp;
      s_bready <= 1'h0;
   endtask : wr

   task automatic rd(logic [11:0] a);
      @(posedge aclk);
      s_araddr <= a;
      s_arvalid <= 1'h1;
      s_rready <= 1'($urandom);
      forever begin
         @(posedge aclk);
         if (s_arready) s_arvalid <= 1'h0;
         if (s_rvalid && s_rready) break;
         if (!s_rready) s_rready <= 1'($urandom);
      end
      d = s_rdata;
      resp = s_rresp;
      s_rready <= 1'h0;
   endtask : rd

   task automatic mwr(int i, logic [31:0] v, logic [3:0] st);
      wr(TA[i], v, st);
      check("trim wresp", 32'(resp), 32'(`COTR_RESP_OKAY));
      if (m_busy || m_ctrl[2:1] == 2'h3) wvio = 1'h1;
      if (st[0]) m_trim[i][7:0] = v[7:0];
      if (st[1]) m_trim[i][15:8] = v[15:8];
   endtask : mwr

   task automatic mrd(int i);
      rd(TA[i]);
      check("trim", d, 32'(m_trim[i]));
      check("trim rresp", 32'(resp), 32'(`COTR_RESP_OKAY));
      if (m_ctrl[0] && !m_ctrl[2] && !m_done) rvio = 1'h1;
      if (m_ctrl[1] && m_ctrl[2] && !m_stop) rvio = 1'h1;
   endtask : mrd

   task automatic mstat();
      rd(STA);
      check("status", d, 32'({rvio, wvio, m_stop, m_done, m_busy}));
   endtask : mstat

   task automatic mout(logic s);
      @(posedge aclk);
      second_core_samples_b <= s;
      repeat (2) @(posedge aclk);
      #1;
      check("first", 32'(first_core_input_b_offset),
         32'(m_trim[0][11:0]));
      check("second", 32'(second_core_offset),
         32'(m_trim[s ? 2 : 1][11:0]));
      check("enables", 32'({background_offset_calibration_enable,
         background_calibration_enable,
         foreground_offset_calibration_enable}), 32'(m_ctrl));
   endtask : mout

   task automatic rst();
      @(posedge aclk);
      aresetn <= 1'h0;
      factory_first_core_input_b <= 12'($urandom);
      factory_second_core_input_a <= 12'($urandom);
      factory_second_core_input_b <= 12'($urandom);
      repeat (3) @(posedge aclk);
      aresetn <= 1'h1;
      m_trim[0] = {4'h0, factory_first_core_input_b};
      m_trim[1] = {4'h0, factory_second_core_input_a};
      m_trim[2] = {4'h0, factory_second_core_input_b};
      {m_ctrl, m_busy, m_done, m_stop, wvio, rvio} = 8'h0;
   endtask : rst

   task automatic end_sim();
      $display("errors %0d checks %0d", errors, total_checks);
      if (errors == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : end_sim

   initial begin
      void'($urandom(17));
      // Second pass is a mid-run reset with fresh factory values
      repeat (2) begin
         rst();
         for (int i = 0; i < 3; i++) mrd(i);
         mout(1'h0);
         for (int k = 0; k < 12; k++) begin
            mwr(k % 3, $urandom, 4'($urandom));
            mrd(k % 3);
            mout(1'($urandom));
         end
      end
      for (int c = 0; c < 8; c++) begin
         wr(CTL, 32'(c), 4'h1);
         m_ctrl = 3'(c);
         {foreground_calibration_busy, foreground_calibration_done_flag,
            calibration_stopped_flag} <= 3'(c);
         {m_busy, m_done, m_stop} = 3'(c);
         rd(CTL);
         check("ctrl", d, 32'(c));
         mwr(c % 3, $urandom, 4'h3);
         mrd(c % 3);
         mout(c[0]);
         mstat();
         wr(STA, 32'h18, 4'h1);
         {wvio, rvio} = 2'h0;
         mstat();
      end
      wr(12'h300, $urandom, 4'hf);
      check("bad wresp", 32'(resp), 32'(`COTR_RESP_SLVERR));
      rd(12'h300);
      check("bad rdata", d, 32'h0);
      check("bad rresp", 32'(resp), 32'(`COTR_RESP_SLVERR));
      end_sim();
   end

   initial begin
      #2000000;
      errors++;
      end_sim();
   end
endmodule : testbench
